// *** hdl/dps_pkg.sv ***
// Purpose: Constants and types for the port mode and vector sequencer
// Assumes: 100 MHz system clock, eight-bit ports
// Notes:   Shared by the sequencer and its bench
`default_nettype none
package dps_pkg;
  localparam int unsigned NUM_PORTS   = 12;
  localparam int unsigned PORT_W      = 8;
  localparam int unsigned MAX_VECTORS = 256;
  localparam int unsigned CNT_W       = 4;
  localparam int unsigned VADDR_W     = 8;
  localparam int unsigned VLEN_W      = 9;

  // Host command codes
  typedef enum logic [3:0] {
    DPS_CMD_WRITE      = 4'h0,
    DPS_CMD_READ       = 4'h1,
    DPS_CMD_SET_SYNC   = 4'h2,
    DPS_CMD_SET_DIR    = 4'h3,
    DPS_CMD_SET_LEN    = 4'h4,
    DPS_CMD_LOAD_VEC   = 4'h5,
    DPS_CMD_READ_VEC   = 4'h6,
    DPS_CMD_SET_EDGE   = 4'h7,
    DPS_CMD_ARM_ON     = 4'h8,
    DPS_CMD_ARM_OFF    = 4'h9,
    DPS_CMD_QUERY_CFG  = 4'hA
  } dps_cmd_t;

  typedef enum logic {
    DPS_IDLE,
    DPS_ARMED
  } dps_state_t;

  localparam logic [7:0] ASYNC_RESET_DATA = 8'h00;
endpackage : dps_pkg
`default_nettype wire

// *** hdl/dps_sequencer.sv ***
// Purpose: Port mode selection and clocked vector sequencing for a 12-port digital I/O unit
// Assumes: One host command per cycle on cmd_valid; answer one cycle later on rsp_valid
// Notes:   Vector clock is sampled by clk, two flops, then edge detected
//
// Notes on behaviour
// - Each port asynchronous or synchronous, host selected
// - Sync port count set by setup command
// - Reset makes every port asynchronous
// - Setup query reports every port's mode anytime
// - Async ports move data only on commands
// - Async ports never take part in vectors
// - Async commands refused while armed
// - Async write presets a sync output port
// - Async read of sync input refused
// - Sync ports act on vector clock edges
// - Armed only by the arm-enable command
// - One vector per edge, auto disarm after last
// - Arm-cancel disarms at once, dropping vectors
// - At most 256 vectors per port
// - Sync ports contiguous from port zero
// - Vector clock ignored unless armed
// - Sync setup commands refused while armed
`default_nettype none
module dps_sequencer #(
  parameter int unsigned NPORT = dps_pkg::NUM_PORTS,
  parameter int unsigned DEPTH = dps_pkg::MAX_VECTORS
) (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_b,
  // Host commands
  input  wire logic                           cmd_valid,
  input  wire logic [3:0]                     cmd_code,
  input  wire logic [dps_pkg::CNT_W-1:0]      cmd_port,
  input  wire logic [dps_pkg::VLEN_W-1:0]     cmd_arg,
  input  wire logic [dps_pkg::PORT_W-1:0]     cmd_data,
  // Host answers
  output logic                                rsp_valid,
  output logic                                rsp_error,
  output logic [dps_pkg::PORT_W-1:0]          rsp_data,
  output logic [NPORT-1:0]                    rsp_sync_map,
  output logic [NPORT-1:0]                    rsp_dir_map,
  output logic                                armed,
  // Test equipment link
  input  wire logic                           vector_clock_input,
  // Port pins
  input  wire logic [NPORT*dps_pkg::PORT_W-1:0] port_in,
  output logic [NPORT*dps_pkg::PORT_W-1:0]    port_out,
  output logic [NPORT-1:0]                    port_oe
);
  localparam int unsigned PW = dps_pkg::PORT_W;
  localparam int unsigned AW = dps_pkg::VADDR_W;
  localparam int unsigned LW = dps_pkg::VLEN_W;

  dps_pkg::dps_state_t  state_q;
  logic [dps_pkg::CNT_W-1:0] sync_cnt_q;
  logic [NPORT-1:0]     dir_out_q;
  logic                 edge_rise_q;
  logic [LW-1:0]        vec_len_q;
  logic [LW-1:0]        vec_idx_q;
  logic [2:0]           vclk_sync_q;
  logic [NPORT*PW-1:0]  pin_s1_q;
  logic [NPORT*PW-1:0]  pin_s2_q;
  logic [PW-1:0]        vec_mem [NPORT][DEPTH];
  logic [NPORT-1:0]     sync_map;
  logic                 vclk_edge;
  logic                 vec_step;
  logic                 last_vec;
  logic                 cmd_ok;
  dps_pkg::dps_cmd_t    cmd;

  assign cmd = dps_pkg::dps_cmd_t'(cmd_code);

  // Mask of ports below the sync count
  function automatic logic [NPORT-1:0] sync_mask(input logic [dps_pkg::CNT_W-1:0] n);
    logic [NPORT-1:0] m;
    m = '0;
    for (int i = 0; i < NPORT; i++) begin
      m[i] = (i < int'(n));
    end
    return m;
  endfunction

  assign sync_map = sync_mask(sync_cnt_q);

  // Vector clock synchroniser and edge finder
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vclk_sync_q <= 3'h0;
    end else begin
      vclk_sync_q <= {vclk_sync_q[1:0], vector_clock_input};
    end
  end

  assign vclk_edge = edge_rise_q ? (vclk_sync_q[1] & ~vclk_sync_q[2])
                                 : (~vclk_sync_q[1] & vclk_sync_q[2]);
  assign vec_step  = (state_q == dps_pkg::DPS_ARMED) && vclk_edge;
  assign last_vec  = (vec_idx_q + LW'(1)) >= vec_len_q;

  // Pin input synchroniser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= port_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Command legality
  always_comb begin
    cmd_ok = 1'b1;
    if (state_q == dps_pkg::DPS_ARMED) begin
      cmd_ok = (cmd == dps_pkg::DPS_CMD_ARM_OFF) || (cmd == dps_pkg::DPS_CMD_QUERY_CFG);
    end else if (cmd == dps_pkg::DPS_CMD_READ) begin
      cmd_ok = !(sync_map[cmd_port] && !dir_out_q[cmd_port]);
    end else if (cmd == dps_pkg::DPS_CMD_SET_SYNC) begin
      cmd_ok = (int'(cmd_arg) <= NPORT);
    end else if (cmd == dps_pkg::DPS_CMD_SET_LEN) begin
      cmd_ok = (int'(cmd_arg) <= DEPTH) && (cmd_arg != '0);
    end else if (cmd == dps_pkg::DPS_CMD_ARM_ON) begin
      cmd_ok = (sync_cnt_q != '0);
    end else if (cmd > dps_pkg::DPS_CMD_QUERY_CFG) begin
      cmd_ok = 1'b0;
    end
    if (int'(cmd_port) >= NPORT && (cmd == dps_pkg::DPS_CMD_WRITE || cmd == dps_pkg::DPS_CMD_READ
        || cmd == dps_pkg::DPS_CMD_SET_DIR || cmd == dps_pkg::DPS_CMD_LOAD_VEC
        || cmd == dps_pkg::DPS_CMD_READ_VEC)) begin
      cmd_ok = 1'b0;
    end
  end

  // Arm state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= dps_pkg::DPS_IDLE;
      vec_idx_q <= '0;
    end else if (cmd_valid && cmd_ok && cmd == dps_pkg::DPS_CMD_ARM_OFF) begin
      state_q <= dps_pkg::DPS_IDLE;
    end else if (cmd_valid && cmd_ok && cmd == dps_pkg::DPS_CMD_ARM_ON) begin
      state_q   <= dps_pkg::DPS_ARMED;
      vec_idx_q <= '0;
    end else if (vec_step) begin
      vec_idx_q <= vec_idx_q + LW'(1);
      if (last_vec) begin
        state_q <= dps_pkg::DPS_IDLE;
      end
    end
  end

  // Setup registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_cnt_q  <= '0;
      dir_out_q   <= '0;
      vec_len_q   <= LW'(1);
      edge_rise_q <= 1'b1;
    end else if (cmd_valid && cmd_ok) begin
      if (cmd == dps_pkg::DPS_CMD_SET_SYNC) begin
        sync_cnt_q <= dps_pkg::CNT_W'(cmd_arg);
      end else if (cmd == dps_pkg::DPS_CMD_SET_DIR) begin
        dir_out_q[cmd_port] <= cmd_data[0];
      end else if (cmd == dps_pkg::DPS_CMD_SET_LEN) begin
        vec_len_q <= cmd_arg;
      end else if (cmd == dps_pkg::DPS_CMD_SET_EDGE) begin
        edge_rise_q <= cmd_data[0];
      end
    end
  end

  // Per-port vector memory, drive and capture
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    always_ff @(posedge clk) begin
      if (cmd_valid && cmd_ok && cmd == dps_pkg::DPS_CMD_LOAD_VEC && int'(cmd_port) == p) begin
        vec_mem[p][AW'(cmd_arg)] <= cmd_data;
      end else if (vec_step && sync_map[p] && !dir_out_q[p]) begin
        vec_mem[p][AW'(vec_idx_q)] <= pin_s2_q[p*PW +: PW];
      end
    end

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        port_out[p*PW +: PW] <= dps_pkg::ASYNC_RESET_DATA;
        port_oe[p]           <= 1'b0;
      end else begin
        port_oe[p] <= dir_out_q[p];
        if (cmd_valid && cmd_ok && cmd == dps_pkg::DPS_CMD_WRITE && int'(cmd_port) == p) begin
          port_out[p*PW +: PW] <= cmd_data;
        end else if (vec_step && sync_map[p] && dir_out_q[p]) begin
          port_out[p*PW +: PW] <= vec_mem[p][AW'(vec_idx_q)];
        end
      end
    end
  end

  // Host answers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid    <= 1'b0;
      rsp_error    <= 1'b0;
      rsp_data     <= '0;
      rsp_sync_map <= '0;
      rsp_dir_map  <= '0;
      armed        <= 1'b0;
    end else begin
      armed        <= (state_q == dps_pkg::DPS_ARMED);
      rsp_valid    <= cmd_valid;
      rsp_error    <= cmd_valid && !cmd_ok;
      rsp_sync_map <= sync_map;
      rsp_dir_map  <= dir_out_q;
      if (cmd_valid && cmd_ok && cmd == dps_pkg::DPS_CMD_READ) begin
        rsp_data <= pin_s2_q[int'(cmd_port)*PW +: PW];
      end else if (cmd_valid && cmd_ok && cmd == dps_pkg::DPS_CMD_READ_VEC) begin
        rsp_data <= vec_mem[cmd_port][AW'(cmd_arg)];
      end else if (cmd_valid) begin
        rsp_data <= '0;
      end
    end
  end

  // Checks
  // Armed vector edge not overtaken by a cancel in the same cycle
  sequence armed_edge_s;
    state_q == dps_pkg::DPS_ARMED && vclk_edge && !(cmd_valid && cmd == dps_pkg::DPS_CMD_ARM_OFF);
  endsequence

  reset_async_a: assert property (@(posedge clk) $rose(rst_b) |-> sync_cnt_q == '0)
    else $error("sync count not zero after reset");
  map_contig_a: assert property (@(posedge clk) disable iff (!rst_b)
    ((sync_map + NPORT'(1)) & sync_map) == '0)
    else $error("sync ports not contiguous");
  armed_refuse_a: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_valid && state_q == dps_pkg::DPS_ARMED && cmd == dps_pkg::DPS_CMD_WRITE |=> rsp_error)
    else $error("async write accepted while armed");
  sync_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_valid && cmd == dps_pkg::DPS_CMD_READ && sync_map[cmd_port] && !dir_out_q[cmd_port] |=> rsp_error)
    else $error("sync input read accepted");
  arm_only_cmd_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(state_q == dps_pkg::DPS_ARMED) |-> $past(cmd_valid) && $past(cmd) == dps_pkg::DPS_CMD_ARM_ON)
    else $error("armed without arm command");
  cancel_arm_a: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_valid && cmd == dps_pkg::DPS_CMD_ARM_OFF |=> state_q == dps_pkg::DPS_IDLE)
    else $error("arm cancel ignored");
  step_adv_a: assert property (@(posedge clk) disable iff (!rst_b)
    armed_edge_s |=> vec_idx_q == $past(vec_idx_q) + LW'(1))
    else $error("vector index did not advance");
  auto_disarm_a: assert property (@(posedge clk) disable iff (!rst_b)
    armed_edge_s and last_vec |=> state_q == dps_pkg::DPS_IDLE)
    else $error("no disarm after last vector");
  idle_clock_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == dps_pkg::DPS_IDLE && !cmd_valid |=> $stable(vec_idx_q))
    else $error("vector clock acted while idle");
  setup_armed_a: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_valid && state_q == dps_pkg::DPS_ARMED && cmd == dps_pkg::DPS_CMD_SET_SYNC |=> $stable(sync_cnt_q))
    else $error("sync setup changed while armed");
  len_limit_a: assert property (@(posedge clk) disable iff (!rst_b)
    int'(vec_len_q) <= DEPTH)
    else $error("vector length above depth");
  async_excl_a: assert property (@(posedge clk) disable iff (!rst_b)
    armed_edge_s and !sync_map[NPORT-1] |=> $stable(port_out[(NPORT-1)*PW +: PW]))
    else $error("async port changed on vector");

  // Command handshake and bookkeeping checks
  sequence refused_s;
    cmd_valid && !cmd_ok;
  endsequence

  sequence sync_set_s;
    cmd_valid && cmd_ok && cmd == dps_pkg::DPS_CMD_SET_SYNC;
  endsequence

  rsp_pair_a: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_valid |=> rsp_valid)
    else $error("command got no answer");

  refuse_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    refused_s |=> rsp_error)
    else $error("refused command not flagged");

  accept_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_valid && cmd_ok |=> !rsp_error)
    else $error("accepted command flagged");

  query_map_a: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> rsp_sync_map == $past(sync_map))
    else $error("mode report stale");

  count_cmd_a: assert property (@(posedge clk) disable iff (!rst_b)
    sync_set_s |=> sync_cnt_q == dps_pkg::CNT_W'($past(cmd_arg)))
    else $error("sync count not taken");

  idx_bound_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == dps_pkg::DPS_ARMED |-> vec_idx_q < vec_len_q)
    else $error("armed past last vector");

  reset_idle_a: assert property (@(posedge clk)
    $rose(rst_b) |-> state_q == dps_pkg::DPS_IDLE && dir_out_q == '0)
    else $error("not idle after reset");

  oe_dir_a: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> port_oe == $past(dir_out_q))
    else $error("drive enable not following direction");

  armed_out_a: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> armed == $past(state_q == dps_pkg::DPS_ARMED))
    else $error("armed output not following state");

  // Ports above the sync count stay out of vectors
  // even while other ports run clocked
endmodule : dps_sequencer
`default_nettype wire

// *** verification/dps_equip_model.sv ***
// Purpose: Test equipment model driving the vector clock and the port pins
// Assumes: Vector clock idles low between frames, 160 ns period
// Notes:   Pins turn to their inverse once the hold time has run out
`default_nettype none
module dps_equip_model (
  // Link to the sequencer
  output logic        vector_clock_input,
  output logic [95:0] port_in
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    vector_clock_input = 1'b0;
    port_in            = '0;
  end

  task automatic set_pins(input logic [95:0] v);
    port_in = v;
  endtask

  // One active edge, pins held well around it
  task automatic pulse(input logic [95:0] v);
    port_in = v;
    #40 vector_clock_input = 1'b1;
    #80 vector_clock_input = 1'b0;
    #40 port_in = ~v;
  endtask
endmodule // dps_equip_model
`default_nettype wire

// *** verification/tb_digital_io_port_mode_sequencer.sv ***
// Purpose: Self-checking bench for the port mode and vector sequencer
// Assumes: 100 MHz clock, answers one cycle after each command
// Notes:   Ports 0 and 1 run synchronously, port 5 stays asynchronous
`default_nettype none
module tb_digital_io_port_mode_sequencer;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, rst_b, cmd_valid, rsp_valid, rsp_error, armed, vclk;
  logic [3:0]  cmd_code, cmd_port;
  logic [8:0]  cmd_arg;
  logic [7:0]  cmd_data, rsp_data, got;
  logic [11:0] sync_map, dir_map, port_oe;
  logic [95:0] port_in, port_out;
  int          n_mismatch, n_tests;

  dps_sequencer #(.NPORT(12), .DEPTH(256)) u_dut (
    .clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_port(cmd_port),
    .cmd_arg(cmd_arg), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
    .rsp_data(rsp_data), .rsp_sync_map(sync_map), .rsp_dir_map(dir_map), .armed(armed),
    .vector_clock_input(vclk), .port_in(port_in), .port_out(port_out), .port_oe(port_oe));
  dps_equip_model u_eq (.vector_clock_input(vclk), .port_in(port_in));

  always #5 clk = ~clk;

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cmd(input dps_pkg::dps_cmd_t c, input logic [3:0] p, input logic [8:0] a,
                     input logic [7:0] d, input logic err);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    cmd_port  <= p;
    cmd_arg   <= a;
    cmd_data  <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    chk("rsp_valid", 16'(rsp_valid), 16'h1);
    chk("rsp_error", 16'(rsp_error), 16'(err));
    got = rsp_data;
    @(posedge clk);
    #1;
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic t_setup;
    chk("sync_map", 16'(sync_map), 16'h0);
    chk("port_oe", 16'(port_oe), 16'h0);
    cmd(dps_pkg::DPS_CMD_SET_SYNC, 4'h0, 9'h00D, 8'h00, 1'b1);
    cmd(dps_pkg::DPS_CMD_SET_SYNC, 4'h0, 9'h002, 8'h00, 1'b0);
    chk("sync_map", 16'(sync_map), 16'h003);
    cmd(dps_pkg::DPS_CMD_QUERY_CFG, 4'h0, 9'h000, 8'h00, 1'b0);
    chk("query map", 16'(sync_map), 16'h003);
    cmd(dps_pkg::DPS_CMD_SET_LEN, 4'h0, 9'h101, 8'h00, 1'b1);
    cmd(dps_pkg::DPS_CMD_SET_LEN, 4'h0, 9'h100, 8'h00, 1'b0);
    cmd(dps_pkg::DPS_CMD_SET_LEN, 4'h0, 9'h002, 8'h00, 1'b0);
  endtask

  task automatic t_async;
    u_eq.set_pins(96'h96_0000_0000_0000);
    cmd(dps_pkg::DPS_CMD_SET_DIR, 4'h5, 9'h000, 8'h01, 1'b0);
    cmd(dps_pkg::DPS_CMD_WRITE, 4'h5, 9'h000, 8'h5A, 1'b0);
    chk("port5 out", 16'(port_out[47:40]), 16'h5A);
    chk("port5 oe", 16'(port_oe[5]), 16'h1);
    cmd(dps_pkg::DPS_CMD_READ, 4'h6, 9'h000, 8'h00, 1'b0);
    chk("port6 read", 16'(got), 16'h96);
  endtask

  task automatic t_sync;
    cmd(dps_pkg::DPS_CMD_SET_DIR, 4'h0, 9'h000, 8'h01, 1'b0);
    cmd(dps_pkg::DPS_CMD_LOAD_VEC, 4'h0, 9'h000, 8'hA1, 1'b0);
    cmd(dps_pkg::DPS_CMD_LOAD_VEC, 4'h0, 9'h001, 8'hB2, 1'b0);
    cmd(dps_pkg::DPS_CMD_WRITE, 4'h0, 9'h000, 8'h3C, 1'b0);
    chk("preset", 16'(port_out[7:0]), 16'h3C);
    cmd(dps_pkg::DPS_CMD_READ, 4'h1, 9'h000, 8'h00, 1'b1);
    u_eq.pulse(96'h5500);
    chk("idle edge", 16'(port_out[7:0]), 16'h3C);
    cmd(dps_pkg::DPS_CMD_ARM_ON, 4'h0, 9'h000, 8'h00, 1'b0);
    chk("armed", 16'(armed), 16'h1);
    cmd(dps_pkg::DPS_CMD_WRITE, 4'h5, 9'h000, 8'h11, 1'b1);
    cmd(dps_pkg::DPS_CMD_SET_LEN, 4'h0, 9'h003, 8'h00, 1'b1);
    cmd(dps_pkg::DPS_CMD_QUERY_CFG, 4'h0, 9'h000, 8'h00, 1'b0);
    u_eq.pulse(96'hC700);
    chk("vec0", 16'(port_out[7:0]), 16'hA1);
    chk("async held", 16'(port_out[47:40]), 16'h5A);
    chk("armed mid", 16'(armed), 16'h1);
    u_eq.pulse(96'h2E00);
    chk("vec1", 16'(port_out[7:0]), 16'hB2);
    chk("auto disarm", 16'(armed), 16'h0);
    cmd(dps_pkg::DPS_CMD_READ_VEC, 4'h1, 9'h000, 8'h00, 1'b0);
    chk("cap0", 16'(got), 16'hC7);
    cmd(dps_pkg::DPS_CMD_READ_VEC, 4'h1, 9'h001, 8'h00, 1'b0);
    chk("cap1", 16'(got), 16'h2E);
  endtask

  task automatic t_cancel;
    cmd(dps_pkg::DPS_CMD_ARM_ON, 4'h0, 9'h000, 8'h00, 1'b0);
    u_eq.pulse(96'h0);
    chk("rearm vec0", 16'(port_out[7:0]), 16'hA1);
    cmd(dps_pkg::DPS_CMD_ARM_OFF, 4'h0, 9'h000, 8'h00, 1'b0);
    chk("cancel", 16'(armed), 16'h0);
    u_eq.pulse(96'h0);
    chk("dropped", 16'(port_out[7:0]), 16'hA1);
  endtask

  task automatic t_edge_reset;
    cmd(dps_pkg::DPS_CMD_SET_EDGE, 4'h0, 9'h000, 8'h00, 1'b0);
    cmd(dps_pkg::DPS_CMD_WRITE, 4'h0, 9'h000, 8'h3C, 1'b0);
    cmd(dps_pkg::DPS_CMD_ARM_ON, 4'h0, 9'h000, 8'h00, 1'b0);
    u_eq.pulse(96'h0);
    chk("fall vec0", 16'(port_out[7:0]), 16'hA1);
    chk("fall armed", 16'(armed), 16'h1);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    chk("rst armed", 16'(armed), 16'h0);
    chk("rst map", 16'(sync_map), 16'h0);
    chk("rst out", 16'(port_out[7:0]), 16'h00);
    cmd(dps_pkg::DPS_CMD_READ, 4'h1, 9'h000, 8'h00, 1'b0);
  endtask

  initial begin
    clk        = 1'b0;
    rst_b      = 1'b0;
    cmd_valid  = 1'b0;
    cmd_code   = 4'h0;
    cmd_port   = 4'h0;
    cmd_arg    = 9'h000;
    cmd_data   = 8'h00;
    n_mismatch = 0;
    n_tests    = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_setup();
    t_async();
    t_sync();
    t_cancel();
    t_edge_reset();
    test_done();
  end

  // Hang guard
  initial begin
    #100us;
    n_mismatch++;
    test_done();
  end
endmodule // tb_digital_io_port_mode_sequencer
`default_nettype wire
